// ### core/sac_ctrl.sv
// Successive-approximation converter control with APB registers
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
module sac_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end
  output sac_pkg::sac_analog_t analog,
  output logic converter_on,
  input wire logic comp_above,
  input wire logic osc_tick,
  // Core interface
  input wire logic core_asleep,
  output logic conv_irq,
  output logic wake_req,
  output logic isr_branch
);

  // ==========================================================
  // Synchronisers for pin-side inputs
  // Every pin passes two flops before any logic reads it
  logic comp_s1, comp_s2, osc_s1, osc_s2, osc_s3, sleep_s1, sleep_s2;
  // Comparator answer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {comp_s1, comp_s2} <= 2'h0;
    end else begin
      {comp_s1, comp_s2} <= {comp_above, comp_s1};
    end
  end

  // Oscillator level; third flop only feeds the edge detect
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {osc_s1, osc_s2, osc_s3} <= 3'h0;
    end else begin
      {osc_s1, osc_s2, osc_s3} <= {osc_tick, osc_s1, osc_s2};
    end
  end

  // Sleep indication from the core
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {sleep_s1, sleep_s2} <= 2'h0;
    end else begin
      {sleep_s1, sleep_s2} <= {core_asleep, sleep_s1};
    end
  end
  logic osc_edge;
  // Rising oscillator edge; flops reset to the idle low level
  assign osc_edge = osc_s2 && !osc_s3;

  // ==========================================================
  // Registers and state
  logic [7:0] control, analog_clk, periph_en, periph_flags, core_int;
  localparam int RESULT_W = sac_pkg::RESULT_BITS;
  // Justify slices and the 4-bit period count assume ten bits
  if (RESULT_W != 10 || sac_pkg::CONV_PERIODS > 15) begin : g_bad_width
    $error("sac_ctrl serves only a ten-bit result");
  end
  logic [RESULT_W-1:0] result;
  logic [RESULT_W-1:0] trial;
  logic [3:0] period_cnt;
  sac_pkg::sac_state_t state;
  logic tick;
  logic conv_done;

  // Bus decode
  // Zero wait states: ready follows the access phase directly
  logic wr_en, rd_phase;
  assign wr_en = psel && penable && pwrite;
  assign rd_phase = psel && !pwrite;
  assign pready = psel && penable;
  logic addr_ok;
  assign addr_ok = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
  assign pslverr = pready && !addr_ok;
  logic wr_ctl, wr_ack, wr_pen, wr_pfl, wr_core;
  assign wr_ctl = wr_en && (paddr == sac_pkg::OFF_CONTROL);
  assign wr_ack = wr_en && (paddr == sac_pkg::OFF_ANALOG_CLK);
  assign wr_pen = wr_en && (paddr == sac_pkg::OFF_PERIPH_EN);
  assign wr_pfl = wr_en && (paddr == sac_pkg::OFF_PERIPH_FLAGS);
  assign wr_core = wr_en && (paddr == sac_pkg::OFF_CORE_INT);

  // Control field views
  logic is_on, start_bit, justify_left, clk_osc, sleep_kill;
  assign is_on = control[sac_pkg::CTL_ON];
  assign start_bit = control[sac_pkg::CTL_START];
  assign justify_left = control[sac_pkg::CTL_JUSTIFY];
  assign clk_osc = (analog_clk[sac_pkg::ACK_CLK_LO +: 2] == 2'h3);
  // Sleep aborts any conversion not clocked by the oscillator
  assign sleep_kill = sleep_s2 && !clk_osc;

  // Start request: on bit already set before this write
  logic start_req;
  assign start_req = wr_ctl && pwdata[sac_pkg::CTL_START] && is_on
                     && (state == sac_pkg::SAC_IDLE);
  // Software abort: start bit written low, on bit low or sleep kill mid-conversion
  logic sw_abort;
  assign sw_abort = (state == sac_pkg::SAC_CONV || state == sac_pkg::SAC_WAKE)
                    && ((wr_ctl && !pwdata[sac_pkg::CTL_START]) || !is_on || sleep_kill);

  // ==========================================================
  // Bit period tick, divided from system clock or oscillator
  logic tick_run;
  assign tick_run = (state != sac_pkg::SAC_IDLE);
  sac_tick_gen #(
    .DIV_W(6)
  ) u_tick (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .run(tick_run),
    .clk_sel(analog_clk[sac_pkg::ACK_CLK_LO +: 3]),
    .osc_tick(osc_edge),
    .tick(tick)
  );

  // Completion when last of eleven periods ends
  assign conv_done = (state == sac_pkg::SAC_CONV) && tick
                     && (period_cnt == 4'(sac_pkg::CONV_PERIODS - 1)) && !sw_abort;

  // Start bit falls on completion or on any abort
  logic clear_start;
  assign clear_start = conv_done || sw_abort;

  // Next trial code: keep or drop current bit, set the one below
  logic [RESULT_W-1:0] next_trial;
  logic [RESULT_W-1:0] cur_bit;
  assign cur_bit = RESULT_W'(1) << (RESULT_W - 32'(period_cnt));
  assign next_trial = (comp_s2 ? trial : (trial & ~cur_bit)) | (cur_bit >> 1);

  // ==========================================================
  // Sequencer and successive approximation
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= sac_pkg::SAC_IDLE;
      period_cnt <= '0;
      trial <= '0;
    end else begin
      unique case (state)
        sac_pkg::SAC_IDLE: begin
          period_cnt <= '0;
          trial <= '0;
          if (start_req) begin
            // Oscillator clock waits one extra period for sleep entry
            state <= clk_osc ? sac_pkg::SAC_WAKE : sac_pkg::SAC_CONV;
          end
        end
        sac_pkg::SAC_WAKE: begin
          if (sw_abort) begin
            state <= sac_pkg::SAC_HOLD;
          end else if (tick) begin
            state <= sac_pkg::SAC_CONV;
            trial <= RESULT_W'(1) << (RESULT_W - 1);
          end
        end
        sac_pkg::SAC_CONV: begin
          if (sw_abort) begin
            state <= sac_pkg::SAC_HOLD;
            period_cnt <= '0;
          end else if (tick) begin
            period_cnt <= period_cnt + 4'h1;
            if (period_cnt == 4'h0) begin
              trial <= RESULT_W'(1) << (RESULT_W - 1);
            end else if (period_cnt <= 4'(RESULT_W)) begin
              // Decide bit period_cnt-1 from MSB down, then try next bit
              trial <= next_trial;
            end
            if (conv_done) begin
              state <= sac_pkg::SAC_IDLE;
            end
          end
        end
        sac_pkg::SAC_HOLD: begin
          if (tick) begin
            period_cnt <= period_cnt + 4'h1;
            if (period_cnt == 4'(sac_pkg::ABORT_PERIODS - 1)) begin
              state <= sac_pkg::SAC_IDLE;
              period_cnt <= '0;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Result store: only on completion, aborts leave it alone
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      result <= '0;
    end else if (conv_done) begin
      result <= next_trial;
    end
  end

  // Start bit only accepted while idle and already powered
  logic [7:0] next_control;
  assign next_control = {pwdata[7:2] & sac_pkg::MASK_CONTROL[7:2],
                         (pwdata[sac_pkg::CTL_START] && start_req) ||
                         (pwdata[sac_pkg::CTL_START] && start_bit && !clear_start),
                         pwdata[sac_pkg::CTL_ON]};

  // ==========================================================
  // Software registers; hardware set wins over software clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      control <= sac_pkg::RST_CONTROL;
      analog_clk <= sac_pkg::RST_ANALOG_CLK;
      periph_en <= sac_pkg::RST_PERIPH_EN;
      periph_flags <= sac_pkg::RST_PERIPH_FLAGS;
      core_int <= sac_pkg::RST_CORE_INT;
    end else begin
      if (wr_ctl) begin
        control <= next_control;
      end else if (clear_start) begin
        control[sac_pkg::CTL_START] <= 1'b0;
      end
      if (wr_ack) begin
        analog_clk <= pwdata[7:0] & sac_pkg::MASK_ANALOG_CLK;
      end
      if (wr_pen) begin
        periph_en <= pwdata[7:0] & sac_pkg::MASK_PERIPH;
      end
      if (wr_pfl) begin
        periph_flags <= pwdata[7:0] & sac_pkg::MASK_PERIPH;
      end
      if (conv_done) begin
        periph_flags[sac_pkg::PER_DONE] <= 1'b1;
      end
      if (wr_core) begin
        core_int <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // Analog drive: channel, reference, trial code
  assign converter_on = is_on;
  assign analog.channel = control[sac_pkg::CTL_CHAN_LO +: 3];
  assign analog.ref_external = control[sac_pkg::CTL_REF];
  assign analog.trial_code = trial;
  assign analog.sample = is_on && (state == sac_pkg::SAC_IDLE);

  // ==========================================================
  // Interrupt request, wake and branch decision
  logic done_pending;
  assign done_pending = periph_flags[sac_pkg::PER_DONE] && periph_en[sac_pkg::PER_DONE];
  assign conv_irq = done_pending;
  assign wake_req = done_pending && sleep_s2;
  assign isr_branch = done_pending && core_int[sac_pkg::CORE_GLOBAL]
                      && core_int[sac_pkg::CORE_PERIPH];

  // ==========================================================
  // Result justification and read mux
  logic [7:0] res_high, res_low;
  assign res_high = justify_left ? result[9:2] : {6'h00, result[9:8]};
  assign res_low = justify_left ? {result[1:0], 6'h00} : result[7:0];

  logic [7:0] rd_byte;
  always_comb begin
    unique case (paddr)
      sac_pkg::OFF_CONTROL: rd_byte = control;
      sac_pkg::OFF_ANALOG_CLK: rd_byte = analog_clk;
      sac_pkg::OFF_RESULT_HIGH: rd_byte = res_high;
      sac_pkg::OFF_RESULT_LOW: rd_byte = res_low;
      sac_pkg::OFF_PERIPH_EN: rd_byte = periph_en;
      sac_pkg::OFF_PERIPH_FLAGS: rd_byte = periph_flags;
      sac_pkg::OFF_CORE_INT: rd_byte = core_int;
      sac_pkg::OFF_POWER: rd_byte = {7'h00, sleep_s2};
      default: rd_byte = 8'h00;
    endcase
  end
  assign prdata = (rd_phase && penable) ? {24'h000000, rd_byte} : 32'h00000000;

endmodule

// ### core/sac_pkg.sv
// Package for the successive-approximation converter control block
package sac_pkg;

  // ==========================================================
  // Register byte offsets on the APB bus
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_ANALOG_CLK = 8'h04;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h08;
  localparam logic [7:0] OFF_RESULT_LOW = 8'h0c;
  localparam logic [7:0] OFF_PERIPH_EN = 8'h10;
  localparam logic [7:0] OFF_PERIPH_FLAGS = 8'h14;
  localparam logic [7:0] OFF_CORE_INT = 8'h18;
  localparam logic [7:0] OFF_POWER = 8'h1c;

  // ==========================================================
  // Field positions of the control register
  localparam int CTL_JUSTIFY = 7;
  localparam int CTL_REF = 6;
  localparam int CTL_CHAN_LO = 2;
  localparam int CTL_START = 1;
  localparam int CTL_ON = 0;
  // Analog select and conversion clock register
  localparam int ACK_CLK_LO = 4;
  // Enable and flag bit positions
  localparam int PER_DONE = 6;
  localparam int CORE_GLOBAL = 7;
  localparam int CORE_PERIPH = 6;
  // Power register: bit 0 is the asleep indication
  localparam int PWR_SLEEP = 0;

  // ==========================================================
  // Reset values and write masks
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_ANALOG_CLK = 8'h0f;
  localparam logic [7:0] RST_PERIPH_EN = 8'h00;
  localparam logic [7:0] RST_PERIPH_FLAGS = 8'h00;
  localparam logic [7:0] RST_CORE_INT = 8'h00;
  localparam logic [7:0] MASK_CONTROL = 8'hdf;
  localparam logic [7:0] MASK_ANALOG_CLK = 8'h7f;
  localparam logic [7:0] MASK_PERIPH = 8'h6b;

  // ==========================================================
  // Timing counts in conversion bit periods, result width in bits
  localparam int CONV_PERIODS = 11;
  localparam int ABORT_PERIODS = 2;
  localparam int RESULT_BITS = 10;

  // Conversion clock selections
  localparam logic [2:0] CLK_DIV2 = 3'h0;
  localparam logic [2:0] CLK_DIV4 = 3'h4;
  localparam logic [2:0] CLK_DIV8 = 3'h1;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV64 = 3'h6;

  // Converter sequencer states
  typedef enum logic [3:0] {
    SAC_IDLE = 4'b0001,
    SAC_CONV = 4'b0010,
    SAC_HOLD = 4'b0100,
    SAC_WAKE = 4'b1000
  } sac_state_t;

  // Analog side: channel, reference, trial code, sample strobe
  typedef struct packed {
    logic [2:0] channel;
    logic ref_external;
    logic [RESULT_BITS-1:0] trial_code;
    logic sample;
  } sac_analog_t;

endpackage

// ### core/sac_tick_gen.sv
// Bit period tick generator for the converter clock selection
`timescale 1ns/1ps
module sac_tick_gen #(
  parameter int DIV_W = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Control
  input wire logic run,
  input wire logic [2:0] clk_sel,
  input wire logic osc_tick,
  // Output
  output logic tick
);

  // Divide by 64 needs at least six counter bits
  if (DIV_W < 6) begin : g_bad_div
    $error("sac_tick_gen needs DIV_W of at least 6");
  end

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] limit;
  logic use_osc;
  logic div_tick;

  // Divider terminal count per selection
  always_comb begin
    unique case (clk_sel)
      sac_pkg::CLK_DIV2: limit = DIV_W'(1);
      sac_pkg::CLK_DIV4: limit = DIV_W'(3);
      sac_pkg::CLK_DIV8: limit = DIV_W'(7);
      sac_pkg::CLK_DIV16: limit = DIV_W'(15);
      sac_pkg::CLK_DIV32: limit = DIV_W'(31);
      sac_pkg::CLK_DIV64: limit = DIV_W'(63);
      default: limit = DIV_W'(63);
    endcase
  end

  assign use_osc = (clk_sel[1:0] == 2'h3);
  assign div_tick = run && (count == limit);
  assign tick = use_osc ? (run && osc_tick) : div_tick;

  // System clock divider, idle while stopped
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (!run || div_tick) begin
      count <= '0;
    end else begin
      count <= count + DIV_W'(1);
    end
  end

endmodule

// ### verif/sac_ctrl_asserts.sv
// Port-level checker for the converter control block
`timescale 1ns/1ps
module sac_ctrl_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Converter and core side
  input wire sac_pkg::sac_analog_t analog,
  input wire logic converter_on,
  input wire logic conv_irq,
  input wire logic wake_req,
  input wire logic isr_branch
);
  // ==========================================================
  // Bus strobes
  wire acc = psel && penable;
  wire ctl_wr = acc && pwrite && (paddr == sac_pkg::OFF_CONTROL);

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // Bus answer
  property p_ready; psel && !penable ##1 acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access phase");
  property p_idle; !acc |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
  property p_unmap; acc && paddr >= 8'h20 |-> pslverr && prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access answered");
  // Control fields follow writes only
  property p_on; $changed(converter_on) |-> $past(ctl_wr) && ($past(pwdata[0]) == converter_on);
  endproperty
  a_on: assert property (p_on) else $error("power bit moved without write");
  property p_sel; !$stable({analog.channel, analog.ref_external}) |-> $past(ctl_wr); endproperty
  a_sel: assert property (p_sel) else $error("channel or reference moved");
  // Interrupt outputs
  property p_hold; conv_irq && !(acc && pwrite) |=> conv_irq; endproperty
  a_hold: assert property (p_hold) else $error("request dropped by itself");
  property p_wake; wake_req |-> conv_irq; endproperty
  a_wake: assert property (p_wake) else $error("wake without request");
  property p_isr; isr_branch |-> conv_irq; endproperty
  a_isr: assert property (p_isr) else $error("branch without request");
endmodule

// ### verif/sac_ctrl_tb_top.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
module sac_ctrl_tb_top;
  // ==========================================================
  // Signals
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, converter_on, conv_irq, wake_req, isr_branch, err;
  sac_pkg::sac_analog_t analog;
  logic comp_above = 1'b1, osc_tick = 1'b0, core_asleep = 1'b0;
  int miscompares = 0, total_checks = 0, cyc = 0, n;

  // Clock, oscillator ticks every ten clocks, timeout
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    osc_tick <= (cyc % 10) < 5;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  sac_ctrl uut (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .analog, .converter_on, .comp_above, .osc_tick, .core_asleep,
    .conv_irq, .wake_req, .isr_branch);

  // ==========================================================
  // Bus and compare tasks
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One conversion with its length window and expected result pair
  task automatic conv(input logic [2:0] cs, input logic [7:0] ctl, input int lo, input int hi,
    input logic [7:0] eh, input logic [7:0] el);
    xfer(1'b1, 8'h14, 32'h0);
    chk(32'(conv_irq), 32'h0);
    xfer(1'b1, 8'h04, {25'h0, cs, 4'hf});
    xfer(1'b1, 8'h00, {24'h0, ctl});
    repeat (4) @(posedge core_clk);
    xfer(1'b1, 8'h00, {24'h0, ctl | 8'h02});
    n = 0;
    while (conv_irq !== 1'b1) begin
      @(negedge core_clk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
    chk(32'(analog.channel), 32'(ctl[4:2]));
    chk(32'(analog.ref_external), 32'(ctl[6]));
    chk(32'(converter_on), 32'h1);
    rchk(8'h00, {24'h0, ctl});
    rchk(8'h14, 32'h40);
    rchk(8'h08, {24'h0, eh});
    rchk(8'h0c, {24'h0, el});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    // Reset values and an unmapped place
    rchk(8'h00, 32'h0);
    rchk(8'h04, 32'h0f);
    rchk(8'h10, 32'h0);
    rchk(8'h14, 32'h0);
    rchk(8'h08, 32'h0);
    rchk(8'h20, 32'h0);
    chk(32'(err), 32'h1);
    // Start refused while powered off
    xfer(1'b1, 8'h00, 32'h02);
    rchk(8'h00, 32'h0);
    chk(32'(converter_on), 32'h0);
    xfer(1'b1, 8'h10, 32'h40);
    // Every divider, both formats, several channels and references
    conv(3'h0, 8'h01, 22, 28, 8'h03, 8'hff);
    conv(3'h4, 8'h15, 44, 50, 8'h03, 8'hff);
    conv(3'h1, 8'h41, 88, 94, 8'h03, 8'hff);
    conv(3'h5, 8'h5d, 176, 182, 8'h03, 8'hff);
    conv(3'h2, 8'h81, 352, 358, 8'hff, 8'hc0);
    conv(3'h6, 8'hc9, 704, 710, 8'hff, 8'hc0);
    // Masking, core branch and wake from sleep
    xfer(1'b1, 8'h10, 32'h0);
    chk(32'(conv_irq), 32'h0);
    xfer(1'b1, 8'h10, 32'h40);
    xfer(1'b1, 8'h18, 32'hc0);
    chk(32'(isr_branch), 32'h1);
    @(posedge core_clk);
    core_asleep <= 1'b1;
    repeat (4) @(negedge core_clk);
    chk(32'(wake_req), 32'h1);
    rchk(8'h1c, 32'h1);
    @(posedge core_clk);
    core_asleep <= 1'b0;
    xfer(1'b1, 8'h18, 32'h00);
    chk(32'(isr_branch), 32'h0);
    rchk(8'h14, 32'h40);
    // Abort keeps the old result and refuses a quick restart
    @(posedge core_clk);
    comp_above <= 1'b0;
    xfer(1'b1, 8'h14, 32'h0);
    xfer(1'b1, 8'h00, 32'h03);
    repeat (100) @(posedge core_clk);
    xfer(1'b1, 8'h00, 32'h01);
    xfer(1'b1, 8'h00, 32'h03);
    rchk(8'h00, 32'h01);
    rchk(8'h08, 32'h03);
    rchk(8'h0c, 32'hff);
    rchk(8'h14, 32'h0);
    chk(32'(analog.sample), 32'h0);
    repeat (200) @(posedge core_clk);
    @(negedge core_clk);
    chk(32'(analog.sample), 32'h1);
    // Oscillator clock with one extra period
    conv(3'h3, 8'h01, 110, 140, 8'h00, 8'h00);
    tally_and_finish();
  end
endmodule

bind sac_ctrl sac_ctrl_asserts u_chk (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .analog, .converter_on, .conv_irq, .wake_req,
  .isr_branch);
